//--- hw/crop_params.svh
// Constants of the video crop and decimation stage: register map, field
// positions and reset values. Assumes inclusion by bare name.
`ifndef CROP_PARAMS_SVH
`define CROP_PARAMS_SVH

// ==========================================
// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_HWIN 8'h04
`define OFS_VWIN 8'h08
`define OFS_DROP 8'h0C
`define OFS_TARGET 8'h10
`define OFS_STATUS 8'h14

// ==========================================
// Control fields
`define CTRL_ENABLE 0
`define CTRL_LINE_POL 1
`define CTRL_FIELD_POL 2
`define CTRL_FIELD_SEL 3
`define CTRL_FILT_LSB 4
`define CTRL_RESET 32'h0000_0006

// ==========================================
// Coordinate and count fields
`define LO_LSB 0
`define HI_LSB 16
`define DROP_W 7
`define STAT_OVF 31
`define STAT_PARITY 30

// ==========================================
// Decimation run and filter codes
`define RUN_LEN 7'h40
`define FILT_BYPASS 2'h0
`define FILT_AVG2 2'h1
`define FILT_TAP3 2'h2

`endif

//--- hw/crop_pkg.sv
// Types shared by the crop and decimation stage.
// Assumes nothing of its surroundings.
`default_nettype none

package crop_pkg;

    // ==========================================
    // Horizontal window phase of a line
    typedef enum logic [2:0] {
        LINE_WAIT = 3'h1,
        LINE_TAKE = 3'h2,
        LINE_DONE = 3'h4
    } line_phase_e;

endpackage

`default_nettype wire

//--- hw/skid_buffer.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`default_nettype none

module skid_buffer #(
    parameter int WIDTH = 19
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    logic [WIDTH-1:0] spare;
    logic spare_full;
    wire take_in = in_valid && in_ready;
    wire give_out = out_valid && out_ready;

    // ==========================================
    // Head register feeds the output, spare absorbs one stalled word
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_valid <= 1'b0;
            out_data <= '0;
            spare_full <= 1'b0;
            spare <= '0;
            in_ready <= 1'b1;
        end else begin
            if (!out_valid || give_out) begin
                out_valid <= spare_full || take_in;
                out_data <= spare_full ? spare : in_data;
                if (spare_full) begin
                    spare_full <= take_in;
                    spare <= in_data;
                end
            end else if (take_in) begin
                spare_full <= 1'b1;
                spare <= in_data;
            end
            // Ready drops only once both entries are held
            in_ready <= !(out_valid && !out_ready && (spare_full || take_in))
                && !(spare_full && !give_out);
        end
    end

endmodule

`default_nettype wire

//--- hw/video_input_crop_decimator.sv
// Video input crop and decimation stage with an AHB-Lite register slave.
// Assumes digitizer pins (sync, data, pixel strobe) are asynchronous to
// hclk and each pixel strobe lasts at least one hclk cycle.
`include "crop_params.svh"
`default_nettype none

module video_input_crop_decimator #(
    parameter int COORD_W = 12
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic line_sync,
    input wire logic field_sync,
    input wire logic pixel_strobe,
    input wire logic [15:0] pixel_yuv,
    output logic out_valid,
    input wire logic out_ready,
    output logic [15:0] out_data,
    output logic out_line_start,
    output logic out_field_start,
    output logic out_field_odd
);

    // ==========================================
    // Elaboration check
    generate
        if (COORD_W < 10 || COORD_W > 16) begin : g_bad_width
            $error("COORD_W must lie between 10 and 16");
        end
    endgenerate

    // ==========================================
    // Register state
    logic [31:0] ctrl;
    logic [COORD_W-1:0] first_pixel;
    logic [COORD_W-1:0] last_pixel;
    logic [COORD_W-1:0] first_line;
    logic [COORD_W-1:0] last_line;
    logic [`DROP_W-1:0] pixel_drop_count;
    logic [`DROP_W-1:0] line_drop_count;
    logic [COORD_W-1:0] target_window_width;
    logic [COORD_W-1:0] target_window_height;
    logic overflow;

    wire enable = ctrl[`CTRL_ENABLE];
    wire line_sync_polarity = ctrl[`CTRL_LINE_POL];
    wire field_sync_polarity = ctrl[`CTRL_FIELD_POL];
    wire field_display_select = ctrl[`CTRL_FIELD_SEL];
    wire [1:0] horizontal_filter_select = ctrl[`CTRL_FILT_LSB +: 2];

    // ==========================================
    // AHB-Lite slave: zero wait, writes land in the data phase
    logic wr_pend;
    logic [7:0] wr_addr;
    wire addr_ok = hsel && htrans[1] && hready;
    wire wr_ctrl = wr_pend && wr_addr == `OFS_CTRL;
    wire wr_hwin = wr_pend && wr_addr == `OFS_HWIN;
    wire wr_vwin = wr_pend && wr_addr == `OFS_VWIN;
    wire wr_drop = wr_pend && wr_addr == `OFS_DROP;
    wire wr_target = wr_pend && wr_addr == `OFS_TARGET;
    wire wr_status = wr_pend && wr_addr == `OFS_STATUS;
    logic [31:0] read_mux;
    logic [COORD_W-1:0] line_count;
    logic field_odd;

    // Read data chosen from the address phase; unmapped reads give zero
    always_comb begin
        read_mux = 32'h0000_0000;
        unique case (haddr)
            `OFS_CTRL: read_mux = ctrl;
            `OFS_HWIN: read_mux = {16'(last_pixel), 16'(first_pixel)};
            `OFS_VWIN: read_mux = {16'(last_line), 16'(first_line)};
            `OFS_DROP: read_mux = {16'(line_drop_count), 16'(pixel_drop_count)};
            `OFS_TARGET: read_mux = {16'(target_window_height), 16'(target_window_width)};
            `OFS_STATUS: read_mux = {overflow, field_odd, 14'h0000, 16'(line_count)};
            default: read_mux = 32'h0000_0000;
        endcase
    end

    // Address phase capture and registered answer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend <= addr_ok && hwrite;
            wr_addr <= haddr;
            if (addr_ok && !hwrite) begin
                hrdata <= read_mux;
            end
        end
    end

    // Configuration registers; drop counts saturate at a full run
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= `CTRL_RESET;
            first_pixel <= '0;
            last_pixel <= '1;
            first_line <= '0;
            last_line <= '1;
            pixel_drop_count <= '0;
            line_drop_count <= '0;
            target_window_width <= '1;
            target_window_height <= '1;
        end else begin
            if (wr_ctrl) ctrl <= hwdata & 32'h0000_003F;
            if (wr_hwin) begin
                first_pixel <= hwdata[`LO_LSB +: COORD_W];
                last_pixel <= hwdata[`HI_LSB +: COORD_W];
            end
            if (wr_vwin) begin
                first_line <= hwdata[`LO_LSB +: COORD_W];
                last_line <= hwdata[`HI_LSB +: COORD_W];
            end
            if (wr_drop) begin
                pixel_drop_count <= (hwdata[`LO_LSB +: `DROP_W] > `RUN_LEN) ?
                    `RUN_LEN : hwdata[`LO_LSB +: `DROP_W];
                line_drop_count <= (hwdata[`HI_LSB +: `DROP_W] > `RUN_LEN) ?
                    `RUN_LEN : hwdata[`HI_LSB +: `DROP_W];
            end
            if (wr_target) begin
                target_window_width <= hwdata[`LO_LSB +: COORD_W];
                target_window_height <= hwdata[`HI_LSB +: COORD_W];
            end
        end
    end

    // ==========================================
    // Pin synchronisers; only stage two is looked at
    logic [18:0] pin_meta;
    logic [18:0] pin_sync;
    logic line_lvl_q;
    logic field_lvl_q;
    logic strobe_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= {line_sync, field_sync, pixel_strobe, pixel_yuv};
            pin_sync <= pin_meta;
        end
    end

    // Polarity folds the active edge onto a rising edge
    wire line_lvl = pin_sync[18] ~^ line_sync_polarity;
    wire field_lvl = pin_sync[17] ~^ field_sync_polarity;
    wire strobe_lvl = pin_sync[16];
    wire [15:0] yuv_in = pin_sync[15:0];
    wire line_edge = line_lvl && !line_lvl_q;
    wire field_edge = field_lvl && !field_lvl_q;
    wire pixel_tick = strobe_lvl && !strobe_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_lvl_q <= 1'b0;
            field_lvl_q <= 1'b0;
            strobe_q <= 1'b0;
        end else begin
            line_lvl_q <= line_lvl;
            field_lvl_q <= field_lvl;
            strobe_q <= strobe_lvl;
        end
    end

    // ==========================================
    // Line and pixel counting from the active edges
    logic [COORD_W-1:0] pixel_count;
    crop_pkg::line_phase_e line_phase;
    crop_pkg::line_phase_e next_line_phase;

    // Inclusive limits give last minus first plus one samples
    wire line_in_window = line_count >= first_line && line_count <= last_line;
    wire at_first_pixel = pixel_count == first_pixel;
    wire at_last_pixel = pixel_count == last_pixel;

    always_comb begin
        next_line_phase = line_phase;
        unique case (line_phase)
            crop_pkg::LINE_WAIT: if (pixel_tick && at_first_pixel) begin
                next_line_phase = at_last_pixel ? crop_pkg::LINE_DONE : crop_pkg::LINE_TAKE;
            end
            crop_pkg::LINE_TAKE: if (pixel_tick && at_last_pixel) begin
                next_line_phase = crop_pkg::LINE_DONE;
            end
            crop_pkg::LINE_DONE: next_line_phase = crop_pkg::LINE_DONE;
            default: next_line_phase = crop_pkg::LINE_WAIT;
        endcase
        if (line_edge) next_line_phase = crop_pkg::LINE_WAIT;
    end

    wire pixel_in_window = pixel_tick && (line_phase == crop_pkg::LINE_TAKE
        || (line_phase == crop_pkg::LINE_WAIT && at_first_pixel));

    // Counters saturate so a stray long line never wraps into the window
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pixel_count <= '0;
            line_count <= '0;
            line_phase <= crop_pkg::LINE_DONE;
            field_odd <= 1'b0;
        end else begin
            line_phase <= next_line_phase;
            if (line_edge) begin
                pixel_count <= '0;
            end else if (pixel_tick && pixel_count != '1) begin
                pixel_count <= pixel_count + 1'b1;
            end
            if (field_edge) begin
                line_count <= '0;
                field_odd <= !field_odd;
            end else if (line_edge && line_count != '1) begin
                line_count <= line_count + 1'b1;
            end
        end
    end

    // ==========================================
    // Horizontal filter on luma; chroma passes through
    logic [7:0] y_prev;
    logic [7:0] y_prev2;
    wire [7:0] y_now = yuv_in[15:8];
    wire [8:0] sum2 = 9'(y_now) + 9'(y_prev);
    wire [9:0] sum3 = 10'(y_now) + 10'(y_prev2) + {1'b0, y_prev, 1'b0};
    logic [7:0] y_filt;

    // Code chosen by software once the drop ratio is settled
    always_comb begin
        unique case (horizontal_filter_select)
            `FILT_AVG2: y_filt = sum2[8:1];
            `FILT_TAP3: y_filt = sum3[9:2];
            default: y_filt = y_now;
        endcase
    end

    // Taps load the first sample for later ones; the first sample itself is filtered against taps zeroed at the line edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            y_prev <= 8'h00;
            y_prev2 <= 8'h00;
        end else if (pixel_in_window) begin
            y_prev <= y_now;
            y_prev2 <= (line_phase == crop_pkg::LINE_WAIT) ? y_now : y_prev;
        end else if (line_edge) begin
            y_prev <= 8'h00;
            y_prev2 <= 8'h00;
        end
    end

    // ==========================================
    // Decimation accumulators keep 64 minus drop of every 64
    logic [6:0] pix_acc;
    logic [6:0] line_acc;
    logic line_keep;
    logic line_started;
    logic [COORD_W-1:0] pix_out_count;
    logic [COORD_W-1:0] line_out_count;
    wire [6:0] pix_keep_step = `RUN_LEN - pixel_drop_count;
    wire [6:0] line_keep_step = `RUN_LEN - line_drop_count;
    wire [7:0] pix_sum = 8'(pix_acc) + 8'(pix_keep_step);
    wire [7:0] line_sum = 8'(line_acc) + 8'(line_keep_step);
    wire pix_keep = pix_sum >= 8'(`RUN_LEN);
    wire line_keep_now = line_sum >= 8'(`RUN_LEN);
    wire line_enter = line_edge && line_in_window;

    // Single field mode drops the even field; interlaced takes both
    wire field_taken = !field_display_select || field_odd;

    // Never more than the target window, never more than sampled
    wire within_target = pix_out_count < target_window_width
        && line_out_count <= target_window_height;
    // Line keep already holds the window test made at the line's own edge
    wire push = enable && pixel_in_window && line_keep
        && field_taken && pix_keep && within_target;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pix_acc <= 7'h00;
            line_acc <= 7'h00;
            line_keep <= 1'b0;
            line_started <= 1'b0;
            pix_out_count <= '0;
            line_out_count <= '0;
        end else begin
            if (field_edge) begin
                line_acc <= 7'h00;
                line_out_count <= '0;
                line_keep <= 1'b0;
            end else if (line_enter) begin
                line_acc <= line_keep_now ? 7'(line_sum - 8'(`RUN_LEN)) : line_sum[6:0];
                line_keep <= line_keep_now;
                if (line_keep_now && field_taken) begin
                    line_out_count <= line_out_count + 1'b1;
                end
            end else if (line_edge) begin
                line_keep <= 1'b0;
            end
            if (line_edge) begin
                pix_acc <= 7'h00;
                pix_out_count <= '0;
                line_started <= 1'b0;
            end else if (pixel_in_window) begin
                pix_acc <= pix_keep ? 7'(pix_sum - 8'(`RUN_LEN)) : pix_sum[6:0];
                if (push) begin
                    pix_out_count <= pix_out_count + 1'b1;
                    line_started <= 1'b1;
                end
            end
        end
    end

    // ==========================================
    // Output buffer; the digitizer cannot stall, so a refusal is flagged
    logic buf_ready;
    logic first_word_of_field;
    wire [18:0] buf_in = {field_odd, first_word_of_field, !line_started, yuv_in[7:0], y_filt};
    wire [18:0] buf_out;

    skid_buffer #(.WIDTH(19)) u_out_buffer (
        .hclk(hclk),
        .hresetn(hresetn),
        .in_valid(push),
        .in_ready(buf_ready),
        .in_data(buf_in),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(buf_out)
    );

    assign out_data = {buf_out[7:0], buf_out[15:8]};
    assign out_line_start = buf_out[16];
    assign out_field_start = buf_out[17];
    assign out_field_odd = buf_out[18];

    // Overflow: a new loss wins over a software clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            overflow <= 1'b0;
            first_word_of_field <= 1'b1;
        end else begin
            if (push && !buf_ready) begin
                overflow <= 1'b1;
            end else if (wr_status && hwdata[`STAT_OVF]) begin
                overflow <= 1'b0;
            end
            if (field_edge) begin
                first_word_of_field <= 1'b1;
            end else if (push) begin
                first_word_of_field <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

//--- verif/digitizer_model.sv
// Model of the digitizer feeding the crop stage: syncs, strobe and pixels.
// Assumes the bench calls send_field only while the stage is configured.
`default_nettype none

module digitizer_model (
    input wire logic hclk,
    output logic line_sync,
    output logic field_sync,
    output logic pixel_strobe,
    output logic [15:0] pixel_yuv
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================
    // Idle pins; data flips so a stale word never looks valid
    initial begin
        line_sync = 1'b0;
        field_sync = 1'b0;
        pixel_strobe = 1'b0;
        pixel_yuv = 16'h0000;
    end

    task automatic hold(input int n, input logic flip);
        repeat (n) begin
            if (flip) pixel_yuv <= ~pixel_yuv;
            @(posedge hclk);
        end
    endtask

    // ==========================================
    // One field: luma carries pixel index, chroma line index
    task automatic send_field(input int lines, input int pixels, input logic lpol,
                              input logic fpol);
        @(posedge hclk);
        line_sync <= !lpol; // Idle level set after polarity, so no active edge
        field_sync <= !fpol;
        hold(4, 1);
        field_sync <= fpol;
        hold(4, 1);
        field_sync <= !fpol;
        for (int l = 0; l < lines; l++) begin
            line_sync <= lpol;
            hold(3, 1);
            line_sync <= !lpol;
            hold(2, 1);
            for (int p = 0; p < pixels; p++) begin
                pixel_yuv <= {p[7:0], l[7:0]};
                hold(1, 0);
                pixel_strobe <= 1'b1; // Two cycles high, three low
                hold(2, 0);
                pixel_strobe <= 1'b0;
                hold(2, 1);
            end
        end
        hold(4, 1);
    endtask
endmodule

`default_nettype wire

//--- verif/crop_asserts.sv
// Checker of the crop stage: bus answers, output holding, field selection.
// Assumes it is bound to the top module and sees its ports only.
`default_nettype none

module crop_asserts #(
    parameter int COORD_W = 12
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic line_sync,
    input wire logic field_sync,
    input wire logic pixel_strobe,
    input wire logic [15:0] pixel_yuv,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [15:0] out_data,
    input wire logic out_line_start,
    input wire logic out_field_start,
    input wire logic out_field_odd
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ==========================================
    // Shadow of the control word; strobes against words handed out
    wire take = hsel && htrans[1] && hready;
    logic [5:0] ctrl;
    logic wr_ctrl;
    logic strobe_q;
    logic [31:0] strobes;
    logic [31:0] words;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= 6'h06;
            wr_ctrl <= 1'b0;
            strobe_q <= 1'b0;
            strobes <= 32'h0;
            words <= 32'h0;
        end else begin
            wr_ctrl <= take && hwrite && haddr == 8'h00;
            if (wr_ctrl) ctrl <= hwdata[5:0];
            strobe_q <= pixel_strobe;
            if (pixel_strobe && !strobe_q) strobes <= strobes + 32'h1;
            if (out_valid && out_ready) words <= words + 32'h1;
        end
    end

    AST_HREADY: assert property (hreadyout) else $error("slave inserted a wait");
    AST_HRESP: assert property (!hresp) else $error("slave answered with error");
    AST_OUT_HOLD: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data)
        && $stable(out_line_start) && $stable(out_field_start)) else $error("word not held");
    AST_FIELD_FIRST: assert property (out_valid && out_field_start |-> out_line_start)
        else $error("field start without line start");
    AST_NO_EXCESS: assert property (words <= strobes)
        else $error("more words out than pixels in");
    AST_SINGLE_FIELD: assert property (out_valid && ctrl[3] |-> out_field_odd)
        else $error("even field shown in single field mode");
    AST_ENABLE: assert property ($rose(out_valid) |-> ctrl[0])
        else $error("output while disabled");
    AST_UNMAPPED: assert property (take && !hwrite && haddr >= 8'h18 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    AST_CTRL_READ: assert property (take && !hwrite && haddr == 8'h00
        |=> hrdata == {26'h0, ctrl}) else $error("control readback wrong");
endmodule

bind video_input_crop_decimator crop_asserts #(.COORD_W(COORD_W)) u_asserts (.*);

`default_nettype wire

//--- verif/tb_video_input_crop_decimator.sv
// Bench of the crop stage: registers over AHB-Lite, fields from the model.
// Assumes the design, the model and the checker are compiled first.
`include "crop_params.svh"
`default_nettype none

module tb_video_input_crop_decimator;
    timeunit 1ns;
    timeprecision 1ps;

    logic hclk, hresetn, hsel, hwrite, out_ready;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, r;
    wire logic hready, hreadyout, hresp, line_sync, field_sync, pixel_strobe;
    wire logic out_valid, out_line_start, out_field_start, out_field_odd;
    wire logic [31:0] hrdata;
    wire logic [15:0] pixel_yuv, out_data;
    int fail_count, checked, words, lines, fstarts, evens, len, exp;
    int d_tab[4] = '{0, 10, 63, 64};
    logic [7:0] first_luma;

    assign hready = hreadyout; // Single slave: its ready is the bus ready

    video_input_crop_decimator DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hreadyout, .hresp, .hrdata, .line_sync, .field_sync, .pixel_strobe,
        .pixel_yuv, .out_valid, .out_ready, .out_data, .out_line_start, .out_field_start,
        .out_field_odd);
    digitizer_model u_model (.hclk, .line_sync, .field_sync, .pixel_strobe, .pixel_yuv);

    // ==========================================
    // Clock and a watchdog over the whole run
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    initial begin
        repeat (100000) @(posedge hclk);
        check(0, 1, "run timeout");
        final_report();
    end

    // ==========================================
    // Output monitor: counts words, lines and fields taken
    always @(posedge hclk) begin
        if (out_valid === 1'b1 && out_ready === 1'b1) begin
            words <= words + 1;
            len <= (out_line_start === 1'b1) ? 1 : len + 1;
            if (out_line_start === 1'b1) lines <= lines + 1;
            if (out_line_start === 1'b1 && lines == 0) first_luma <= out_data[15:8];
            if (out_field_start === 1'b1) fstarts <= fstarts + 1;
            if (out_field_odd !== 1'b1) evens <= evens + 1;
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] want, input string what);
        checked++;
        if (got !== want) begin
            fail_count++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, want);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ==========================================
    // Bus tasks: hold each phase until ready is seen high
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        if (n >= 100) begin
            check(0, 1, "bus timeout");
            final_report();
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        r = hrdata; // Read data taken at the closing edge
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] want);
        bus(1'b0, a, 32'h0);
        check(r, want, "register read");
    endtask

    // Wait, bounded, until the output buffer is empty
    task automatic drain;
        int n;
        n = 0;
        repeat (8) @(posedge hclk);
        while (out_valid !== 1'b0 && n < 200) begin
            @(posedge hclk);
            n++;
        end
        if (n >= 200) check(0, 1, "drain timeout");
        repeat (2) @(posedge hclk);
    endtask

    task automatic clear;
        words = 0;
        lines = 0;
        fstarts = 0;
        evens = 0;
        len = 0;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        out_ready = 1'b1;
        fail_count = 0;
        checked = 0;
        clear();
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // Reset values and masks
        rd_chk(`OFS_CTRL, `CTRL_RESET);
        rd_chk(`OFS_HWIN, 32'h0FFF_0000);
        rd_chk(`OFS_VWIN, 32'h0FFF_0000);
        rd_chk(`OFS_TARGET, 32'h0FFF_0FFF);
        rd_chk(8'h20, 32'h0);
        bus(1'b1, `OFS_CTRL, 32'hFFFF_FFFE);
        rd_chk(`OFS_CTRL, 32'h0000_003E);
        // Pixels 3..67, lines 1..2
        bus(1'b1, `OFS_HWIN, 32'h0043_0003);
        bus(1'b1, `OFS_VWIN, 32'h0002_0001);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, `OFS_DROP, d_tab[i]);
            bus(1'b1, `OFS_CTRL, {26'h0, i[1:0], 1'b0, ~i[0], ~i[0], 1'b1});
            clear();
            u_model.send_field(4, 70, ~i[0], ~i[0]);
            drain();
            exp = 65 * (64 - d_tab[i]) / 64; // Restarts per line
            if (exp > 0) check(len, exp, "pixels per line");
            check(words, 2 * exp, "words per field");
            check(fstarts, (exp > 0) ? 1 : 0, "field starts");
            if (i == 0) check(first_luma, 8'h03, "first pixel");
        end
        // Lines 0..64, ten of 64 dropped
        bus(1'b1, `OFS_HWIN, 32'h0000_0000);
        bus(1'b1, `OFS_VWIN, 32'h0040_0000);
        bus(1'b1, `OFS_DROP, 32'h000A_0000);
        bus(1'b1, `OFS_CTRL, 32'h0000_0007);
        repeat (2) begin
            clear();
            u_model.send_field(66, 2, 1'b1, 1'b1);
            drain();
            check(lines, 54, "lines per field");
        end
        // Single field display: two fields in, only the odd one out
        bus(1'b1, `OFS_VWIN, 32'h0001_0000);
        bus(1'b1, `OFS_DROP, 32'h0);
        bus(1'b1, `OFS_CTRL, 32'h0000_000F);
        clear();
        u_model.send_field(3, 2, 1'b1, 1'b1);
        u_model.send_field(3, 2, 1'b1, 1'b1);
        drain();
        check(words, 2, "single field words");
        check(evens, 0, "even words");
        // Stalled receiver: overflow
        bus(1'b1, `OFS_CTRL, 32'h0000_0007);
        bus(1'b1, `OFS_HWIN, 32'h0009_0000);
        clear();
        out_ready <= 1'b0;
        u_model.send_field(1, 10, 1'b1, 1'b1);
        bus(1'b0, `OFS_STATUS, 32'h0);
        check(r[`STAT_OVF], 1'b1, "overflow flag");
        check(out_valid, 1'b1, "word waiting");
        out_ready <= 1'b1;
        drain();
        check(words >= 2 && words <= 3, 1'b1, "words after stall");
        bus(1'b1, `OFS_STATUS, 32'h8000_0000);
        bus(1'b0, `OFS_STATUS, 32'h0);
        check(r[`STAT_OVF], 1'b0, "overflow cleared");
        final_report();
    end
endmodule

`default_nettype wire
